// ### src/sop_pkg.sv
// Shared constants, types and carriers for the sum-of-products array core
package sop_pkg;

  // ==========================================================
  // Array geometry
  localparam int N_CELLS = 8;
  localparam int N_TERMS = 64;
  localparam int N_LINES = 16;
  localparam int TERMS_PER_CELL = 8;
  localparam int ROW_W = 64;
  localparam int ARCH_W = 82;
  localparam int ADDR_W = 6;
  localparam int MEM_ROWS = 33;
  localparam int TERM_OE = 7;

  // ==========================================================
  // Configuration row map
  localparam logic [5:0] ROW_ARRAY_LAST = 6'h1f;
  localparam logic [5:0] ROW_SIG = 6'h20;
  localparam logic [5:0] ROW_RSV_FIRST = 6'h21;
  localparam logic [5:0] ROW_RSV_LAST = 6'h3b;
  localparam logic [5:0] ROW_ARCH = 6'h3c;
  localparam logic [5:0] ROW_SEC = 6'h3d;
  localparam logic [5:0] ROW_ERASE = 6'h3f;
  localparam logic [4:0] SCAN_LAST = 5'h1f;

  // ==========================================================
  // Architecture control word layout
  localparam int ARCH_SYNC_BIT = 0;
  localparam int ARCH_MODE_BIT = 1;
  localparam int ARCH_CFG_LSB = 2;
  localparam int ARCH_POL_LSB = 10;

  // ==========================================================
  // Erased (virgin) values
  localparam logic [81:0] ARCH_ERASED = {82{1'b1}};
  localparam logic [63:0] ROW_ERASED = {64{1'b1}};
  localparam logic SEC_ERASED = 1'b0;

  // ==========================================================
  // Special cells
  localparam int CELL_OUTER_LO = 0;
  localparam int CELL_OUTER_HI = 7;
  localparam int CELL_CENTRAL_LO = 3;
  localparam int CELL_CENTRAL_HI = 4;

  // ==========================================================
  // Power-up reset timing
  localparam int PWRUP_TIME_US = 10;
  localparam int CLK_FREQ_MHZ = 200;
  localparam int POR_CYCLES = PWRUP_TIME_US * CLK_FREQ_MHZ;
  localparam logic [11:0] POR_LAST = 12'(POR_CYCLES - 1);

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    MODE_REG = 3'b001,
    MODE_COMPLEX = 3'b010,
    MODE_SIMPLE = 3'b100
  } sop_mode_e;

  typedef enum logic [1:0] {
    ST_POR = 2'b01,
    ST_RUN = 2'b10
  } sop_state_e;

  typedef struct packed {
    logic [7:0] ded_in;
    logic [7:0] io_in;
    logic clk_pin;
    logic oe_n_pin;
    logic preload_enable_pin;
    logic preload_data_in;
    logic preload_shift_clk;
  } sop_pins_s;

  typedef struct packed {
    sop_pins_s sync1;
    sop_pins_s sync2;
    logic clk_prev;
    logic shift_prev;
    logic [7:0] q;
    logic [63:0] terms;
    logic [63:0] acc;
    logic [15:0] snap;
    logic [4:0] row;
    logic rd_valid;
    logic [4:0] rd_row;
    logic [81:0] arch;
    logic secure;
    logic [11:0] por_cnt;
    sop_state_e state;
    logic [7:0] io_out;
    logic [7:0] io_oe;
    logic sout;
  } sop_core_s;

endpackage

// ### src/sop_cfg_mem.sv
// Configuration memory for the AND array rows and the signature row
`timescale 1ns/1ps
`default_nettype none

module sop_cfg_mem #(
  parameter int ROWS = 33,
  parameter int WIDTH = 64,
  parameter int OUT_W = 82
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic erase,
  input wire logic we,
  input wire logic [5:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [4:0] raddr_a,
  output logic [WIDTH-1:0] rdata_a,
  input wire logic rd_b,
  input wire logic [5:0] raddr_b,
  input wire logic alt_sel,
  input wire logic [OUT_W-1:0] alt_data,
  output logic [OUT_W-1:0] rdata_b
);

  logic [WIDTH-1:0] mem [0:ROWS-1];

  // ==========================================================
  // Storage; erase wins over a write in the same cycle
  always_ff @(posedge clk_sys) begin
    if (erase) begin
      for (int i = 0; i < ROWS; i++) begin
        mem[i] <= sop_pkg::ROW_ERASED;
      end
    end else if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // ==========================================================
  // Registered read ports
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_a <= '0;
      rdata_b <= '0;
    end else begin
      rdata_a <= mem[raddr_a];
      if (rd_b) begin
        rdata_b <= alt_sel ? alt_data : {{(OUT_W-WIDTH){1'b0}}, mem[raddr_b]};
      end
    end
  end

endmodule

`default_nettype wire

// ### src/sop_array_core.sv
// Programmable sum-of-products array core with eight output macrocells
//
// Overview of operation
// - 64 product terms, each ANDing chosen true or complemented input lines.
// - Eight groups of eight terms; non-enable terms ORed into each macrocell.
// - A macrocell pin floats whenever its enable is low.
// - Every macrocell output has its own selectable polarity.
// - One global mode for all macrocells: registered, complex or simple.
// - Registered mode: register cells use 8 terms; combinational use 7 plus enable.
// - Registered cells share the clock pin and the output-enable pin.
// - Complex mode: outer two cells have no input, so at most six I/O.
// - Complex mode: seven data terms, eighth term is the cell enable.
// - Complex and simple modes: clock and enable pins become array inputs.
// - Simple mode: dedicated input or always-on output; central cells output only.
// - Simple mode: all eight terms form the output, none used for enable.
// - Rows 0 to 31 hold 64 bits of array connections each.
// - Row 32 holds a 64-bit signature, readable even when secured.
// - Rows 33 to 59 are reserved and give nothing back.
// - Row 60 holds the 82-bit architecture word: mode, cell and polarity bits.
// - Row 61 security cell; once set, array rows read back blank.
// - Security cell clears only through bulk erase or rst_n.
// - Programming row 63 erases array, architecture, signature and security.
// - Preload shifts serial data into registers on each shift-clock rise, bottom up.
// - Preload loads only registered cells; one bit per registered cell.
// - Registers clear low at power-up within 10 us; enabled pins read high.
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module sop_array_core (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire sop_pkg::sop_pins_s pins,
  output logic [7:0] io_out,
  output logic [7:0] io_oe,
  output logic preload_serial_out,
  input wire logic [5:0] prog_addr,
  input wire logic [81:0] prog_wdata,
  input wire logic prog_write,
  input wire logic prog_read,
  output logic [81:0] prog_rdata
);

  // ==========================================================
  // State and decode signals
  sop_pkg::sop_core_s st;
  sop_pkg::sop_core_s next_st;
  sop_pkg::sop_mode_e mode;
  logic [7:0] cfg;
  logic [7:0] pol;
  logic [7:0] reg_cell;
  logic [7:0] dpol;
  logic [7:0] cell_en;
  logic [7:0] cell_out;
  logic [15:0] lines;
  logic [8:0] chain;
  logic [63:0] scan_data;
  logic [63:0] acc_upd;
  logic line_bit;
  logic clk_rise;
  logic shift_rise;
  logic mem_we;
  logic mem_erase;
  logic alt_sel;
  logic [81:0] alt_data;

  // ==========================================================
  // Global mode decode
  always_comb begin
    cfg = st.arch[sop_pkg::ARCH_CFG_LSB +: 8];
    pol = st.arch[sop_pkg::ARCH_POL_LSB +: 8];
    if (!st.arch[sop_pkg::ARCH_SYNC_BIT]) begin
      mode = sop_pkg::MODE_REG;
    end else if (st.arch[sop_pkg::ARCH_MODE_BIT]) begin
      mode = sop_pkg::MODE_COMPLEX;
    end else begin
      mode = sop_pkg::MODE_SIMPLE;
    end
  end

  // ==========================================================
  // Per-macrocell logic
  assign chain[0] = st.sync2.preload_data_in;

  generate
    for (genvar k = 0; k < sop_pkg::N_CELLS; k++) begin : g_cell
      logic [7:0] grp;
      logic full8;
      logic sum;
      logic outer;
      logic central;
      assign grp = st.terms[8*k +: 8];
      assign outer = (k == sop_pkg::CELL_OUTER_LO) || (k == sop_pkg::CELL_OUTER_HI);
      assign central = (k == sop_pkg::CELL_CENTRAL_LO) || (k == sop_pkg::CELL_CENTRAL_HI);
      assign reg_cell[k] = (mode == sop_pkg::MODE_REG) && !cfg[k];
      // Eighth term joins the sum only where it is not an enable
      assign full8 = reg_cell[k] || (mode == sop_pkg::MODE_SIMPLE);
      assign sum = full8 ? |grp : |grp[sop_pkg::TERM_OE-1:0];
      assign dpol[k] = pol[k] ? sum : ~sum;
      // Pin shows inverted Q, so a cleared register drives high
      assign cell_out[k] = reg_cell[k] ? ~st.q[k] : dpol[k];
      always_comb begin
        case (mode)
          sop_pkg::MODE_REG: begin
            cell_en[k] = reg_cell[k] ? ~st.sync2.oe_n_pin : grp[sop_pkg::TERM_OE];
          end
          sop_pkg::MODE_COMPLEX: begin
            cell_en[k] = grp[sop_pkg::TERM_OE];
          end
          default: begin
            cell_en[k] = central | ~cfg[k];
          end
        endcase
      end
      always_comb begin
        if (mode == sop_pkg::MODE_REG) begin
          lines[8+k] = reg_cell[k] ? st.q[k] : st.sync2.io_in[k];
        end else if (k == sop_pkg::CELL_OUTER_LO) begin
          lines[8+k] = st.sync2.clk_pin;
        end else if (k == sop_pkg::CELL_OUTER_HI) begin
          lines[8+k] = st.sync2.oe_n_pin;
        end else begin
          lines[8+k] = st.sync2.io_in[k];
        end
      end
      assign lines[k] = st.sync2.ded_in[k];
      // Preload chain skips every cell that has no register
      assign chain[k+1] = reg_cell[k] ? st.q[k] : chain[k];
    end
  endgenerate

  // ==========================================================
  // Programming port decode
  always_comb begin
    mem_we = prog_write && (prog_addr <= sop_pkg::ROW_SIG);
    mem_erase = prog_write && (prog_addr == sop_pkg::ROW_ERASE);
    alt_sel = (prog_addr > sop_pkg::ROW_SIG) ||
              ((prog_addr <= sop_pkg::ROW_ARRAY_LAST) && st.secure);
    if (prog_addr == sop_pkg::ROW_ARCH) begin
      alt_data = st.arch;
    end else if (prog_addr == sop_pkg::ROW_SEC) begin
      alt_data = {81'h0, st.secure};
    end else begin
      alt_data = '0;
    end
  end

  // ==========================================================
  // Array scan: one row per cycle, terms ready after 32 rows
  always_comb begin
    // Odd rows connect to the complement of the line
    line_bit = st.snap[st.rd_row[4:1]] ^ st.rd_row[0];
    // A connected cell on a low line kills the term
    acc_upd = st.acc & ~(scan_data & {64{~line_bit}});
  end

  assign clk_rise = st.sync2.clk_pin & ~st.clk_prev;
  assign shift_rise = st.sync2.preload_shift_clk & ~st.shift_prev;

  // ==========================================================
  // Next state
  always_comb begin
    next_st = st;
    next_st.sync1 = pins;
    next_st.sync2 = st.sync1;
    next_st.clk_prev = st.sync2.clk_pin;
    next_st.shift_prev = st.sync2.preload_shift_clk;

    if (mem_erase) begin
      next_st.arch = sop_pkg::ARCH_ERASED;
      next_st.secure = sop_pkg::SEC_ERASED;
    end else if (prog_write && (prog_addr == sop_pkg::ROW_ARCH)) begin
      next_st.arch = prog_wdata;
    end else if (prog_write && (prog_addr == sop_pkg::ROW_SEC)) begin
      // Writes can only set the cell, never clear it
      next_st.secure = st.secure | prog_wdata[0];
    end

    case (st.state)
      sop_pkg::ST_POR: begin
        // Registers held low and clock edges ignored until the delay ends
        next_st.q = '0;
        next_st.io_oe = '0;
        next_st.rd_valid = 1'b0;
        next_st.por_cnt = 12'(st.por_cnt + 12'h001);
        if (st.por_cnt == sop_pkg::POR_LAST) begin
          next_st.state = sop_pkg::ST_RUN;
        end
      end
      sop_pkg::ST_RUN: begin
        next_st.row = 5'(st.row + 5'h01);
        next_st.rd_valid = 1'b1;
        next_st.rd_row = st.row;
        // Lines frozen per pass so all terms see one input set
        if (st.row == 5'h00) begin
          next_st.snap = lines;
        end
        if (st.rd_valid) begin
          if (st.rd_row == sop_pkg::SCAN_LAST) begin
            next_st.terms = acc_upd;
            next_st.acc = '1;
          end else begin
            next_st.acc = acc_upd;
          end
        end
        if (st.sync2.preload_enable_pin) begin
          if (shift_rise) begin
            for (int k = 0; k < sop_pkg::N_CELLS; k++) begin
              if (reg_cell[k]) begin
                next_st.q[k] = chain[k];
              end
            end
          end
        end else if (clk_rise) begin
          for (int k = 0; k < sop_pkg::N_CELLS; k++) begin
            if (reg_cell[k]) begin
              next_st.q[k] = ~dpol[k];
            end
          end
        end
        next_st.io_oe = cell_en;
      end
      default: begin
        next_st.state = sop_pkg::ST_POR;
      end
    endcase
    next_st.io_out = cell_out;
    next_st.sout = st.sync2.preload_enable_pin & chain[8];
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.acc <= '1;
      st.arch <= sop_pkg::ARCH_ERASED;
      st.secure <= sop_pkg::SEC_ERASED;
      st.state <= sop_pkg::ST_POR;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Configuration memory
  sop_cfg_mem #(
    .ROWS(sop_pkg::MEM_ROWS),
    .WIDTH(sop_pkg::ROW_W),
    .OUT_W(sop_pkg::ARCH_W)
  ) u_mem (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .erase(mem_erase),
    .we(mem_we),
    .waddr(prog_addr),
    .wdata(prog_wdata[63:0]),
    .raddr_a(st.row),
    .rdata_a(scan_data),
    .rd_b(prog_read),
    .raddr_b(prog_addr),
    .alt_sel(alt_sel),
    .alt_data(alt_data),
    .rdata_b(prog_rdata)
  );

  assign io_out = st.io_out;
  assign io_oe = st.io_oe;
  assign preload_serial_out = st.sout;

endmodule

`default_nettype wire

// ### testbench/sop_array_core_properties.sv
// Port-level properties of the sum-of-products array core
`timescale 1ns/1ps
`default_nettype none
module sop_array_core_properties (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire sop_pkg::sop_pins_s pins,
  input wire logic [7:0] io_out,
  input wire logic [7:0] io_oe,
  input wire logic preload_serial_out,
  input wire logic [5:0] prog_addr,
  input wire logic [81:0] prog_wdata,
  input wire logic prog_write,
  input wire logic prog_read,
  input wire logic [81:0] prog_rdata
);
  // ==========================================
  // Shadow rows and settle timers
  localparam int SETTLE = sop_pkg::POR_CYCLES + 100;
  logic [81:0] arch;
  logic [63:0] sig;
  logic sec;
  logic sig_ok;
  logic [11:0] por;
  logic [6:0] quiet;
  sop_pkg::sop_pins_s pins_q;
  // Pins reach the outputs only after a full array scan
  wire logic ok = por == 12'(SETTLE) && quiet == 7'h64;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      arch <= sop_pkg::ARCH_ERASED;
      sig <= '0;
      sec <= 1'h0;
      sig_ok <= 1'h0;
      por <= '0;
      quiet <= '0;
      pins_q <= '0;
    end else begin
      pins_q <= pins;
      por <= (por == 12'(SETTLE)) ? por : por + 12'h1;
      quiet <= (prog_write || pins != pins_q) ? 7'h0 : (quiet == 7'h64) ? quiet : quiet + 7'h1;
      if (prog_write && prog_addr == sop_pkg::ROW_ERASE) begin
        arch <= sop_pkg::ARCH_ERASED;
        sig <= sop_pkg::ROW_ERASED;
        sec <= 1'h0;
        sig_ok <= 1'h1;
      end else if (prog_write && prog_addr == sop_pkg::ROW_ARCH) begin
        arch <= prog_wdata;
      end else if (prog_write && prog_addr == sop_pkg::ROW_SIG) begin
        sig <= prog_wdata[63:0];
      end else if (prog_write && prog_addr == sop_pkg::ROW_SEC) begin
        sec <= sec | prog_wdata[0];
      end
    end
  end
  // ==========================================
  // Properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_por_quiet; por < 12'(sop_pkg::POR_CYCLES) |-> io_oe == 8'h00; endproperty
  a_por_quiet: assert property (p_por_quiet) else $error("pin enabled in power-up");
  property p_rsv_zero;
    prog_read && prog_addr >= sop_pkg::ROW_RSV_FIRST && prog_addr <= sop_pkg::ROW_RSV_LAST |=> prog_rdata == '0;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved row read data");
  property p_arch_read; prog_read && prog_addr == sop_pkg::ROW_ARCH |=> prog_rdata == arch; endproperty
  a_arch_read: assert property (p_arch_read) else $error("control word readback");
  property p_secure_blank; prog_read && sec && prog_addr <= sop_pkg::ROW_ARRAY_LAST |=> prog_rdata == '0; endproperty
  a_secure_blank: assert property (p_secure_blank) else $error("array visible while secured");
  property p_sig_read; prog_read && sig_ok && prog_addr == sop_pkg::ROW_SIG |=> prog_rdata == {18'h0, sig}; endproperty
  a_sig_read: assert property (p_sig_read) else $error("signature readback");
  property p_rdata_hold; !prog_read |=> $stable(prog_rdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_preload_idle; !pins.preload_enable_pin [*4] |-> !preload_serial_out; endproperty
  a_preload_idle: assert property (p_preload_idle) else $error("serial out outside preload");
  property p_simple_oe; ok && arch[0] && !arch[1] |-> io_oe == (~arch[9:2] | 8'h18); endproperty
  a_simple_oe: assert property (p_simple_oe) else $error("simple mode enables");
  property p_reg_oe;
    ok && !arch[0] |-> (io_oe & ~arch[9:2]) == (pins.oe_n_pin ? 8'h00 : ~arch[9:2]);
  endproperty
  a_reg_oe: assert property (p_reg_oe) else $error("common enable ignored");
  c_secure_read: cover property (prog_read && sec && prog_addr <= sop_pkg::ROW_ARRAY_LAST);
  c_preload_out: cover property (pins.preload_enable_pin && preload_serial_out);
  c_simple_run: cover property (ok && arch[0] && !arch[1]);
endmodule
`default_nettype wire

// ### testbench/sop_board_model.sv
// Board logic that drives the array pins and resolves the macrocell wires
`timescale 1ns/1ps
`default_nettype none
module sop_board_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] ded,
  input wire logic [7:0] lvl,
  input wire logic oe_n,
  input wire logic pre_en,
  input wire logic pre_d,
  input wire logic clk_go,
  input wire logic sh_go,
  input wire logic [7:0] io_out,
  input wire logic [7:0] io_oe,
  output var sop_pkg::sop_pins_s pins,
  output logic busy
);
  // ==========================================
  // Slow pulses, four cycles high then four low
  logic [3:0] cnt;
  logic sh;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 4'h0;
      sh <= 1'h0;
    end else if (clk_go || sh_go) begin
      cnt <= 4'h8;
      sh <= sh_go;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end
  end
  always_comb begin
    pins.ded_in = ded;
    pins.io_in = (io_oe & io_out) | (~io_oe & lvl);
    pins.clk_pin = !sh && cnt > 4'h4;
    pins.oe_n_pin = oe_n;
    pins.preload_enable_pin = pre_en;
    // Data is held for the whole shift pulse
    pins.preload_data_in = pre_d;
    pins.preload_shift_clk = sh && cnt > 4'h4;
  end
  assign busy = cnt != 4'h0;
endmodule
`default_nettype wire

// ### testbench/programmable_sum_of_products_array_tb_top.sv
// Self-checking bench for the sum-of-products array core
`timescale 1ns/1ps
`default_nettype none
`define CHK(act, exp) chk((act) === (exp))
module programmable_sum_of_products_array_tb_top;
  // ==========================================
  // Signals
  typedef struct {logic [5:0] a; logic w; logic [81:0] d; logic [81:0] e;} sop_row_s;
  localparam logic [81:0] SIG = {18'h3ffff, 64'h0123_4567_89ab_cdef};
  localparam logic [81:0] ARW = {18'h2a5a5, 64'h0f0f_3c3c_5a5a_9696};
  localparam logic [7:0] PAT = 8'h96;
  logic clk_sys = 1'h0;
  logic rst_n = 1'h0;
  logic [5:0] addr = 6'h0;
  logic [81:0] wdata = '0;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic [7:0] ded = 8'h0;
  logic oe_n = 1'h1;
  logic pre_en = 1'h0;
  logic pre_d = 1'h0;
  logic clk_go = 1'h0;
  logic sh_go = 1'h0;
  logic busy;
  logic [7:0] io_out;
  logic [7:0] io_oe;
  logic sout;
  logic [81:0] rdata;
  sop_pkg::sop_pins_s pins;
  int n_fail = 0;
  int samples_checked = 0;
  string tname = "reset";
  sop_row_s rows [6] = '{
    '{6'h3c, 1'h1, ARW, ARW},
    '{6'h20, 1'h1, SIG, {18'h0, SIG[63:0]}},
    '{6'h05, 1'h1, {18'h0, 64'hfedc_ba98_7654_3210}, {18'h0, 64'hfedc_ba98_7654_3210}},
    '{6'h2d, 1'h1, {82{1'h1}}, 82'h0},
    '{6'h3e, 1'h0, 82'h0, 82'h0},
    '{6'h3f, 1'h0, 82'h0, 82'h0}};
  always #2.5 clk_sys = ~clk_sys;
  sop_array_core i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .pins(pins), .io_out(io_out), .io_oe(io_oe),
    .preload_serial_out(sout), .prog_addr(addr), .prog_wdata(wdata), .prog_write(wr), .prog_read(rd),
    .prog_rdata(rdata));
  sop_board_model i_board (.clk_sys(clk_sys), .rst_n(rst_n), .ded(ded), .lvl(8'h0), .oe_n(oe_n),
    .pre_en(pre_en), .pre_d(pre_d), .clk_go(clk_go), .sh_go(sh_go), .io_out(io_out), .io_oe(io_oe),
    .pins(pins), .busy(busy));
  // ==========================================
  // Tasks
  task automatic chk(input logic ok);
    samples_checked++;
    if (!ok) begin
      n_fail++;
      $display("CHECK FAILED t=%0t mismatch in %s", $time, tname);
    end
  endtask
  task automatic wr_row(input logic [5:0] a, input logic [81:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk_sys);
    wr <= 1'h0;
  endtask
  task automatic rd_row(input logic [5:0] a, output logic [81:0] q);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk_sys);
    rd <= 1'h0;
    #1;
    q = rdata;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Board pulses are slow, so wait on the model rather than a fixed count
  task automatic pulse(input logic shift);
    @(posedge clk_sys);
    clk_go <= !shift;
    sh_go <= shift;
    @(posedge clk_sys);
    clk_go <= 1'h0;
    sh_go <= 1'h0;
    #1;
    while (busy) @(posedge clk_sys);
  endtask
  task automatic end_test;
    $display("test %s done", tname);
  endtask
  task automatic finish_test;
    $display("checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    finish_test();
  end
  // ==========================================
  // Sequence
  initial begin
    logic [81:0] q;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'h1;
    rd_row(6'h3c, q);
    `CHK(q, sop_pkg::ARCH_ERASED);
    `CHK(io_oe, 8'h00);
    wr_row(6'h3f, 82'h0);
    end_test();
    tname = "rows";
    foreach (rows[i]) begin
      if (rows[i].w) wr_row(rows[i].a, rows[i].d);
      rd_row(rows[i].a, q);
      `CHK(q, rows[i].e);
    end
    end_test();
    tname = "security";
    wr_row(6'h3d, 82'h1);
    wr_row(6'h3d, 82'h0);
    rd_row(6'h05, q);
    `CHK(q, 82'h0);
    rd_row(6'h20, q);
    `CHK(q, rows[1].e);
    wr_row(6'h3f, 82'h0);
    rd_row(6'h05, q);
    `CHK(q, {18'h0, sop_pkg::ROW_ERASED});
    rd_row(6'h20, q);
    `CHK(q, {18'h0, sop_pkg::ROW_ERASED});
    rd_row(6'h3c, q);
    `CHK(q, sop_pkg::ARCH_ERASED);
    end_test();
    tname = "simple";
    // Term 0 is line 0, term 7 is ~line 0 & line 2, term 15 is line 15
    for (int r = 0; r < 32; r++) begin
      wr_row(6'(r), {18'h0, ~64'(r != 0) & 64'hffff_ffff_ffff_7f7f | {48'h0, r == 30, 7'h0, r == 1 || r == 4, 7'h0}});
    end
    settle(2100);
    for (int i = 0; i < 4; i++) begin
      wr_row(6'h3c, {64'h0, 7'h7f, i[0], 8'h1a, 2'h1});
      ded <= {7'h0, i[1]};
      settle(120);
      `CHK(io_oe, 8'hfd);
      `CHK(io_out[0], i[1] ~^ i[0]);
    end
    // Only the eighth term is true here, through a complemented line
    @(posedge clk_sys);
    ded <= 8'h04;
    settle(120);
    `CHK(io_out[0], 1'h1);
    end_test();
    tname = "complex";
    wr_row(6'h3c, {64'h0, 8'hff, 8'h00, 2'h3});
    settle(120);
    `CHK(io_oe, 8'h03);
    @(posedge clk_sys);
    oe_n <= 1'h0;
    settle(120);
    `CHK(io_oe, 8'h01);
    end_test();
    tname = "registered";
    wr_row(6'h3c, {64'h0, 8'hff, 8'h00, 2'h0});
    oe_n <= 1'h0;
    ded <= 8'h01;
    settle(120);
    `CHK(io_out, 8'hff);
    `CHK(io_oe, 8'hff);
    pulse(1'h0);
    settle(10);
    `CHK(io_out, 8'h01);
    @(posedge clk_sys);
    oe_n <= 1'h1;
    settle(10);
    `CHK(io_oe, 8'h00);
    end_test();
    tname = "preload";
    @(posedge clk_sys);
    oe_n <= 1'h0;
    pre_en <= 1'h1;
    for (int i = 7; i >= 0; i--) begin
      pre_d <= PAT[i];
      pulse(1'h1);
    end
    settle(10);
    `CHK(sout, PAT[7]);
    @(posedge clk_sys);
    pre_en <= 1'h0;
    settle(10);
    `CHK(io_out, ~PAT);
    `CHK(sout, 1'h0);
    end_test();
    tname = "partial";
    wr_row(6'h3c, {64'h0, 8'hff, 8'hf0, 2'h0});
    pre_en <= 1'h1;
    for (int i = 3; i >= 0; i--) begin
      pre_d <= ~PAT[i];
      pulse(1'h1);
    end
    settle(10);
    `CHK(sout, ~PAT[3]);
    `CHK(io_out[3:0], PAT[3:0]);
    `CHK(io_oe, 8'h0f);
    end_test();
    finish_test();
  end
endmodule
bind sop_array_core sop_array_core_properties i_props (.clk_sys(clk_sys), .rst_n(rst_n), .pins(pins),
  .io_out(io_out), .io_oe(io_oe), .preload_serial_out(preload_serial_out), .prog_addr(prog_addr),
  .prog_wdata(prog_wdata), .prog_write(prog_write), .prog_read(prog_read), .prog_rdata(prog_rdata));
`default_nettype wire
